// [bench/fcp_far.sv]
// far-side pulse source driving the count pins
`timescale 1ns/10ps
`default_nettype none
module fcp_far (
   input wire logic clk,
   output logic pin_a,
   output logic pin_b
);
   // ============================================================
   // pins rest low between pulses
   initial begin
      pin_a = 1'h0;
      pin_b = 1'h0;
   end
   // pulses long enough to clear the two-flop syncs, never overlapping
   task automatic step(input logic up, input int n);
      repeat (n) begin
         @(posedge clk);
         if (up)
            pin_a <= 1'h1;
         else
            pin_b <= 1'h1;
         repeat (4) @(posedge clk);
         pin_a <= 1'h0;
         pin_b <= 1'h0;
         repeat (3) @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [bench/fcp_monitor.sv]
// port-level assertions for the fast counter preset output block
`timescale 1ns/10ps
`default_nettype none
module fcp_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic limit_output_load_op,
   input wire fcp_pkg::fcp_params_t load_params,
   input wire logic cfg_bidir,
   input wire logic acc_clear_op,
   input wire logic acc_write_op,
   input wire logic [15:0] acc_write_val,
   input wire logic irq_allow_op,
   input wire logic irq_block_op,
   input wire logic fast_count_op,
   input wire logic acc_copy_bit,
   input wire logic prog_out_we,
   input wire logic [15:0] prog_out_val,
   input wire logic [15:0] force_out_en,
   input wire logic [15:0] force_out_val,
   input wire logic [15:0] phys_out,
   input wire logic [15:0] image_acc,
   input wire logic [15:0] hw_acc,
   input wire logic isr_start,
   input wire logic load_fault,
   input wire fcp_pkg::fcp_status_t status
);
   // one domain, so clock and reset are given once
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ============================================================
   // named steps
   // enable bit reads back set one cycle after the enable strobe
   sequence s_allow_seen;
      ##1 status.irq_allow_bit;
   endsequence
   // ============================================================
   // checks
   a_bad_load_flagged: assert property (
      limit_output_load_op && $signed(load_params.high_lim) <=
      $signed(cfg_bidir ? load_params.low_lim : 16'h0000) |=> load_fault)
      else $error("invalid load not flagged");
   a_write_loads_acc: assert property (
      acc_write_op && !acc_clear_op |=> hw_acc == $past(acc_write_val) &&
      image_acc == $past(acc_write_val) && status[8:0] == 9'h000)
      else $error("accumulator write wrong");
   a_clear_zeroes_all: assert property (
      acc_clear_op |=> hw_acc == 16'h0000 && image_acc == 16'h0000 &&
      status[8:0] == 9'h000)
      else $error("clear left state behind");
   a_prog_write_wins: assert property (
      prog_out_we && force_out_en == 16'h0000 |=> phys_out == $past(prog_out_val))
      else $error("program write lost");
   a_force_out_wins: assert property (
      1'h1 |=> ((phys_out ^ $past(force_out_val)) & $past(force_out_en)) == 16'h0000)
      else $error("forced output not held");
   a_one_cause_bit: assert property ($onehot0(status.cause))
      else $error("more than one cause set");
   a_start_needs_allow: assert property (
      isr_start |-> $past(status.irq_allow_bit) || $past(irq_allow_op))
      else $error("routine started while blocked");
   a_drop_after_queue: assert property (
      $rose(status.dropped_flag) |-> $past(status.queued_flag))
      else $error("dropped set without queued");
   a_allow_sets_bit: assert property (irq_allow_op |-> s_allow_seen)
      else $error("enable bit not set");
   a_block_clears_bit: assert property (
      irq_block_op && !irq_allow_op |=> !status.irq_allow_bit)
      else $error("enable bit not cleared");
   a_copy_takes_live: assert property (
      (acc_copy_bit || fast_count_op) && !acc_clear_op && !acc_write_op
      |=> image_acc == $past(hw_acc))
      else $error("image accumulator not refreshed");
endmodule
bind fcp_top fcp_monitor i_fcp_monitor (.clk, .nrst, .limit_output_load_op,
   .load_params, .cfg_bidir, .acc_clear_op, .acc_write_op, .acc_write_val,
   .irq_allow_op, .irq_block_op, .fast_count_op, .acc_copy_bit, .prog_out_we,
   .prog_out_val, .force_out_en, .force_out_val, .phys_out, .image_acc,
   .hw_acc, .isr_start, .load_fault, .status);
`default_nettype wire

// [bench/fcp_top_test.sv]
// self-checking bench for the fast counter preset output block
`timescale 1ns/10ps
`default_nettype none
module fcp_top_test;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic [11:0] ops = 12'h000;  // one-cycle strobes, index per instruction
   logic fin_en = 1'h0;
   logic [1:0] fin = 2'h0;
   logic ssi = 1'h0;  // single-scan idle
   logic bidir = 1'h1;  // counter type, 1 bidirectional
   logic [15:0] wv = 16'h0000;
   logic [15:0] pov = 16'h0000;
   logic [15:0] fen = 16'h0000;
   logic [15:0] fval = 16'h0000;
   logic [15:0] isr_n = 16'h0000;  // routine starts seen
   logic [15:0] fault_n = 16'h0000;  // load faults seen
   fcp_pkg::fcp_params_t ld = '0;
   logic pin_a;
   logic pin_b;
   logic [15:0] phys_out;
   logic [15:0] out_image;
   logic [15:0] image_acc;
   logic [15:0] hw_acc;
   logic isr_start;
   logic load_fault;
   fcp_pkg::fcp_status_t status;
   int fail_count = 0;
   int checks_done = 0;
   // ============================================================
   // clock, partner, design
   always #4 clk = ~clk;
   fcp_far i_fcp_far (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));
   fcp_top i_fcp_top (.clk(clk), .nrst(nrst), .pin_a(pin_a), .pin_b(pin_b),
      .pin_z(1'h0), .pin_hold(1'h0), .force_in_en(fin_en), .force_in_val(fin),
      .cfg_bidir(bidir), .cfg_quad(1'h0), .limit_output_load_op(ops[0]),
      .load_params(ld), .acc_clear_op(ops[1]), .acc_write_op(ops[2]),
      .acc_write_val(wv), .instr_high_lim(wv), .irq_allow_op(ops[3]),
      .irq_block_op(ops[4]), .fast_count_op(ops[5]), .fast_count_rung(1'h1),
      .acc_copy_bit(ops[6]), .image_sync_op(ops[7]), .irq_poll(ops[8]),
      .prog_out_we(ops[9]), .prog_out_val(pov), .isr_done(ops[10]),
      .single_scan_idle(ssi), .scan_trigger(ops[11]), .force_out_en(fen),
      .force_out_val(fval), .phys_out(phys_out), .out_image(out_image),
      .image_acc(image_acc), .hw_acc(hw_acc), .isr_start(isr_start),
      .load_fault(load_fault), .status(status));
   // pulses are one cycle wide, so count them as they pass
   always @(posedge clk) begin
      if (isr_start === 1'h1)
         isr_n <= isr_n + 16'h0001;
      if (load_fault === 1'h1)
         fault_n <= fault_n + 16'h0001;
   end
   // ============================================================
   // tasks
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task op(input int b);
      @(posedge clk);
      ops[b] <= 1'h1;
      @(posedge clk);
      ops <= 12'h000;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // loads never change preset and mask together near the old preset
   task ld_op(input fcp_pkg::fcp_params_t p);
      @(posedge clk);
      ld <= p;
      op(0);
   endtask
   task cnt(input logic up, input int n);
      i_fcp_far.step(up, n);
      #1;
   endtask
   // bounded wait for the routine start count
   task wait_n(input logic [15:0] n);
      for (int i = 0; i < 100 && isr_n !== n; i++) @(posedge clk);
      #1;
      checks_done++;
      if (isr_n !== n) begin
         fail_count++;
         $display("Error %0t: routine starts %0d", $time, isr_n);
         stop_test();
      end
   endtask
   task stop_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ============================================================
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      #1;
      chk({15'h0000, status.irq_allow_bit}, 16'h0001);
      $display("test reset done");
      // high preset 2, low preset -2, low nibble under counter control
      ld_op({16'h000F, 16'h00F5, 16'h0002, 16'h00FA, 16'hFFFE});
      cnt(1'h1, 2);
      chk(phys_out, 16'h0005);
      chk({12'h000, status.cause}, 16'h0001);
      wait_n(16'h0001);
      // routine still running: second hit queues, third is dropped
      cnt(1'h0, 1);
      cnt(1'h1, 1);
      chk({15'h0000, status.queued_flag}, 16'h0001);
      cnt(1'h0, 1);
      cnt(1'h1, 1);
      chk({15'h0000, status.dropped_flag}, 16'h0001);
      op(10);
      wait_n(16'h0002);
      op(10);
      $display("test queue done");
      cnt(1'h0, 4);
      chk(hw_acc, 16'hFFFE);
      chk(phys_out, 16'h000A);
      chk({12'h000, status.cause}, 16'h0002);
      chk(out_image, 16'h0000);
      op(7);
      chk(out_image, 16'h000A);
      op(10);
      $display("test low preset done");
      @(posedge clk);
      pov <= 16'h1230;
      op(9);
      chk(phys_out, 16'h1230);
      @(posedge clk);
      fen <= 16'h00FF;
      fval <= 16'h0055;
      repeat (2) @(posedge clk);
      #1;
      chk(phys_out, 16'h1255);
      @(posedge clk);
      fen <= 16'h0000;
      $display("test program write done");
      op(4);
      cnt(1'h1, 4);
      chk(isr_n, 16'h0003);
      chk({15'h0000, status.queued_flag}, 16'h0001);
      chk(phys_out, 16'h1235);
      op(3);
      wait_n(16'h0004);
      op(10);
      $display("test blocked done");
      ld_op({16'hFFFF, 16'hFFFF, 16'h0002, 16'hFFFF, 16'h0005});
      chk(fault_n, 16'h0001);
      cnt(1'h0, 1);
      cnt(1'h1, 1);
      chk(phys_out, 16'h1235);
      wait_n(16'h0005);
      op(10);
      $display("test fault done");
      @(posedge clk);
      ssi <= 1'h1;
      cnt(1'h0, 1);
      cnt(1'h1, 1);
      chk(hw_acc, 16'h0002);
      chk(isr_n, 16'h0005);
      op(11);
      wait_n(16'h0006);
      @(posedge clk);
      ssi <= 1'h0;
      op(10);
      $display("test single scan done");
      cnt(1'h0, 1);
      op(5);
      chk(image_acc, 16'h0001);
      // forced phase a rise counts like a real edge
      @(posedge clk);
      fin_en <= 1'h1;
      repeat (3) @(posedge clk);
      fin <= 2'h2;
      repeat (3) @(posedge clk);
      fin <= 2'h0;
      repeat (3) @(posedge clk);
      fin_en <= 1'h0;
      repeat (6) @(posedge clk);
      #1;
      chk(hw_acc, 16'h0002);
      op(6);
      chk(image_acc, 16'h0002);
      op(10);
      $display("test copy done");
      @(posedge clk);
      wv <= 16'hFFFF;
      op(2);
      chk(image_acc, 16'hFFFF);
      chk({7'h00, status[8:0]}, 16'h0000);
      cnt(1'h0, 1);
      op(1);
      chk(hw_acc, 16'h0000);
      chk({7'h00, status[8:0]}, 16'h0000);
      op(10);
      $display("test clear done");
      // up counter: clear reloads the high preset from the instruction
      @(posedge clk);
      bidir <= 1'h0;
      wv <= 16'h0003;
      op(1);
      cnt(1'h1, 2);
      chk({12'h000, status.cause}, 16'h0000);
      cnt(1'h1, 1);
      chk({12'h000, status.cause}, 16'h0001);
      // up counter load keeps the old low words
      ld_op({16'h000F, 16'h00F6, 16'h0005, 16'h00F9, 16'h0004});
      cnt(1'h1, 2);
      chk(phys_out, 16'h1236);
      @(posedge clk);
      bidir <= 1'h1;
      cnt(1'h0, 1);
      chk(phys_out, 16'h1236);
      $display("test up counter done");
      // wrap both ways through the signed limits
      @(posedge clk);
      wv <= 16'h7FFF;
      op(2);
      cnt(1'h1, 1);
      chk({12'h000, status.cause}, 16'h0004);
      chk({15'h0000, status.top_wrap_flag}, 16'h0001);
      cnt(1'h0, 1);
      chk({12'h000, status.cause}, 16'h0008);
      chk(hw_acc, 16'h7FFF);
      $display("test wrap done");
      stop_test();
   end
endmodule
`default_nettype wire

// [hdl/fcp_pkg.sv]
// package: types, constants and state layout for the fast counter preset output block
package fcp_pkg;
   // ============================================================
   // widths and encodings
   localparam int unsigned DATA_W = 16;          // accumulator, presets, masks
   localparam int unsigned OUT_W = 16;           // physical output lines
   localparam logic [15:0] ACC_MAX = 16'h7FFF;   // +32767
   localparam logic [15:0] ACC_MIN = 16'h8000;   // -32768
   localparam logic [15:0] ACC_ZERO = 16'h0000;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [15:0] HIGH_MIN_UP = 16'h0001;  // up counter high preset floor

   // ============================================================
   // timing: output update and staged preset latency
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned OUT_UPDATE_NS = 30000;   // 30 us longest
   localparam int unsigned PRESET_LAG_NS = 40000;   // 40 us longest
   localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
   localparam int unsigned PRESET_LAG_CYC = PRESET_LAG_NS / CLK_PERIOD_NS;
   // preset follows mask/source one cycle later, well inside the bound
   localparam logic [2:0] PRESET_STAGE_CYC = 3'h1;

   // ============================================================
   // event causes, one-hot cause field bit positions
   localparam int unsigned CAUSE_TOP_MARK = 0;
   localparam int unsigned CAUSE_LOW_MARK = 1;
   localparam int unsigned CAUSE_TOP_WRAP = 2;
   localparam int unsigned CAUSE_LOW_WRAP = 3;
   localparam logic [3:0] CAUSE_NONE = 4'h0;

   // interrupt dispatcher states
   typedef enum logic [1:0] {
      FCP_IRQ_IDLE,
      FCP_IRQ_RUN
   } fcp_irq_state_t;

   // parameter set loaded by the limit/output load operation
   typedef struct packed {
      logic [15:0] mask;
      logic [15:0] high_src;
      logic [15:0] high_lim;
      logic [15:0] low_src;
      logic [15:0] low_lim;
   } fcp_params_t;

   // status flags visible to the program
   typedef struct packed {
      logic irq_allow_bit;
      logic queued_flag;
      logic dropped_flag;
      logic top_wrap_flag;
      logic low_wrap_flag;
      logic count_done_flag;
      logic [3:0] cause;       // top_mark, low_mark, top_wrap, low_wrap
   } fcp_status_t;

   // one-hot event bundle
   typedef struct packed {
      logic top_mark;
      logic low_mark;
      logic top_wrap;
      logic low_wrap;
   } fcp_event_t;
endpackage

// [hdl/fcp_sync.sv]
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none
module fcp_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   // ============================================================
   // state
   typedef struct packed {
      logic [WIDTH-1:0] meta;   // first stage, only read by second
      logic [WIDTH-1:0] stab;   // second stage
   } fcp_sync_state_t;

   fcp_sync_state_t st;
   fcp_sync_state_t next_st;

   // shift pins through both stages
   always_comb begin
      next_st.meta = d;
      next_st.stab = st.meta;
   end

   // synchronous reset to all zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.stab;
endmodule
`default_nettype wire

// [hdl/fcp_top.sv]
// fast counter with preset-driven masked outputs and interrupt bookkeeping
`timescale 1ns/10ps
`default_nettype none
module fcp_top (
   input wire logic clk,
   input wire logic nrst,
   // count pins: up pulse/phase a, down/phase b, z (synchronised but unused), hold
   input wire logic pin_a,
   input wire logic pin_b,
   input wire logic pin_z,
   input wire logic pin_hold,
   // forces on count inputs, same clock domain
   input wire logic force_in_en,
   input wire logic [1:0] force_in_val,
   // configuration: 0 up counter, 1 bidirectional, quad selects encoder
   input wire logic cfg_bidir,
   input wire logic cfg_quad,
   // program instructions, one-cycle strobes
   input wire logic limit_output_load_op,
   input wire fcp_pkg::fcp_params_t load_params,
   input wire logic acc_clear_op,
   input wire logic acc_write_op,
   input wire logic [15:0] acc_write_val,
   input wire logic [15:0] instr_high_lim,
   input wire logic irq_allow_op,
   input wire logic irq_block_op,
   input wire logic fast_count_op,
   input wire logic fast_count_rung,
   input wire logic acc_copy_bit,
   input wire logic image_sync_op,
   input wire logic irq_poll,
   input wire logic prog_out_we,
   input wire logic [15:0] prog_out_val,
   // service routine handshake and test mode
   input wire logic isr_done,
   input wire logic single_scan_idle,
   input wire logic scan_trigger,
   // output forces
   input wire logic [15:0] force_out_en,
   input wire logic [15:0] force_out_val,
   // results
   output logic [15:0] phys_out,
   output logic [15:0] out_image,
   output logic [15:0] image_acc,
   output logic [15:0] hw_acc,
   output logic isr_start,
   output logic load_fault,
   output fcp_pkg::fcp_status_t status
);
   // ============================================================
   // pin synchronisers
   logic [3:0] pins_s;   // a, b, z, hold after two flops
   fcp_sync #(.WIDTH(4)) i_fcp_sync (
      .clk(clk),
      .nrst(nrst),
      .d({pin_a, pin_b, pin_z, pin_hold}),
      .q(pins_s)
   );

   // ============================================================
   // state of the whole block
   typedef struct packed {
      logic [1:0] in_prev;              // previous a, b for edge detect
      logic [15:0] acc;                 // hardware accumulator
      logic [15:0] img_acc;             // image accumulator
      fcp_pkg::fcp_params_t hw;         // live hardware parameters
      logic [15:0] stage_high;          // preset waiting to follow mask
      logic [15:0] stage_low;
      logic stage_pend;
      logic [15:0] out_lat;             // counter/program driven output latch
      logic [15:0] oimg;                // output image
      logic img_stale;                  // counter changed outputs since image
      fcp_pkg::fcp_irq_state_t irq;
      logic isr_go;
      logic fault;
      logic [15:0] phys;
      fcp_pkg::fcp_status_t st;
   } fcp_state_t;

   fcp_state_t s;
   fcp_state_t next_s;

   // ============================================================
   // combinational helpers
   logic [1:0] in_now;       // effective a, b after forces
   logic a_rise;
   logic a_fall;
   logic up_step;
   logic dn_step;
   logic [15:0] acc_step;
   fcp_pkg::fcp_event_t ev;
   logic any_ev;
   logic load_ok;
   logic [15:0] new_out;

   // forced inputs look exactly like pin transitions
   always_comb begin
      in_now = force_in_en ? force_in_val : pins_s[3:2];
      a_rise = in_now[1] && !s.in_prev[1];
      a_fall = !in_now[1] && s.in_prev[1];
      up_step = 1'b0;
      dn_step = 1'b0;
      if (fast_count_rung && !pins_s[0]) begin
         if (!cfg_bidir) begin
            up_step = a_rise;
         end else if (cfg_quad) begin
            // phase b low selects direction from a edge
            up_step = a_rise && !in_now[0];
            dn_step = a_fall && !in_now[0];
         end else begin
            // up/down pulses: up pulses on a, down on b
            up_step = a_rise;
            dn_step = in_now[0] && !s.in_prev[0];
         end
      end
      // signed wrap arithmetic, two's complement 16 bit
      acc_step = s.acc;
      if (up_step && !dn_step) begin
         acc_step = s.acc + 16'h0001;
      end else if (dn_step && !up_step) begin
         acc_step = s.acc - 16'h0001;
      end
   end

   // preset and wrap detection against live (old until staged) presets
   always_comb begin
      ev.top_wrap = up_step && !dn_step && (s.acc == fcp_pkg::ACC_MAX);
      ev.low_wrap = dn_step && !up_step && (s.acc == fcp_pkg::ACC_MIN) && cfg_bidir;
      ev.top_mark = (up_step && !dn_step) && (acc_step == s.hw.high_lim);
      ev.low_mark = cfg_bidir && (dn_step && !up_step) && (acc_step == s.hw.low_lim);
      any_ev = ev.top_wrap || ev.low_wrap || ev.top_mark || ev.low_mark;
   end

   // validity of a parameter load
   always_comb begin
      if (cfg_bidir) begin
         load_ok = $signed(load_params.high_lim) > $signed(load_params.low_lim);
      end else begin
         load_ok = ($signed(load_params.high_lim) >= $signed(fcp_pkg::HIGH_MIN_UP));
      end
   end

   // masked output pattern from current mask/source
   always_comb begin
      new_out = s.out_lat;
      if (ev.top_mark) begin
         new_out = (s.out_lat & ~s.hw.mask) | (s.hw.high_src & s.hw.mask);
      end else if (ev.low_mark) begin
         new_out = (s.out_lat & ~s.hw.mask) | (s.hw.low_src & s.hw.mask);
      end
   end

   // ============================================================
   // next state
   always_comb begin
      next_s = s;
      next_s.in_prev = in_now;
      next_s.acc = acc_step;
      next_s.isr_go = 1'b0;
      next_s.fault = 1'b0;

      // staged preset follows mask/source by one cycle
      if (s.stage_pend) begin
         next_s.hw.high_lim = s.stage_high;
         next_s.hw.low_lim = s.stage_low;
         next_s.stage_pend = 1'b0;
      end

      // counter driven outputs land the cycle after the hit
      if (ev.top_mark || ev.low_mark) begin
         next_s.out_lat = new_out;
         next_s.img_stale = 1'b1;
      end
      // program write is later in fixed order, so it wins
      if (prog_out_we) begin
         next_s.out_lat = prog_out_val;
         next_s.oimg = prog_out_val;
         next_s.img_stale = 1'b0;
      end else if ((irq_poll || image_sync_op) && s.img_stale) begin
         // image catches up with the counter's changes
         next_s.oimg = s.out_lat;
         // a hit in this very cycle is not in the copy, keep it stale
         next_s.img_stale = ev.top_mark || ev.low_mark;
      end

      // event flags and cause
      if (ev.top_wrap) begin
         next_s.st.top_wrap_flag = 1'b1;
      end
      if (ev.low_wrap) begin
         next_s.st.low_wrap_flag = 1'b1;
      end
      if (ev.top_mark || ev.low_mark) begin
         next_s.st.count_done_flag = 1'b1;
      end
      if (any_ev) begin
         next_s.st.cause = fcp_pkg::CAUSE_NONE;
         if (ev.top_wrap) begin
            next_s.st.cause[fcp_pkg::CAUSE_TOP_WRAP] = 1'b1;
         end else if (ev.low_wrap) begin
            next_s.st.cause[fcp_pkg::CAUSE_LOW_WRAP] = 1'b1;
         end else if (ev.top_mark) begin
            next_s.st.cause[fcp_pkg::CAUSE_TOP_MARK] = 1'b1;
         end else begin
            next_s.st.cause[fcp_pkg::CAUSE_LOW_MARK] = 1'b1;
         end
      end

      // interrupt dispatch
      unique case (s.irq)
         fcp_pkg::FCP_IRQ_IDLE: begin
            if (any_ev) begin
               if (s.st.irq_allow_bit && !single_scan_idle && !s.st.queued_flag) begin
                  next_s.isr_go = 1'b1;
                  next_s.irq = fcp_pkg::FCP_IRQ_RUN;
               end else if (s.st.queued_flag) begin
                  next_s.st.dropped_flag = 1'b1;
               end else begin
                  next_s.st.queued_flag = 1'b1;
               end
            end else if (s.st.queued_flag && s.st.irq_allow_bit &&
                         (!single_scan_idle || scan_trigger)) begin
               // held event runs once allowed, and in single scan only on a trigger
               next_s.st.queued_flag = 1'b0;
               next_s.isr_go = 1'b1;
               next_s.irq = fcp_pkg::FCP_IRQ_RUN;
            end
         end
         fcp_pkg::FCP_IRQ_RUN: begin
            if (any_ev) begin
               if (s.st.queued_flag) begin
                  next_s.st.dropped_flag = 1'b1;
               end else begin
                  next_s.st.queued_flag = 1'b1;
               end
            end
            if (isr_done) begin
               next_s.irq = fcp_pkg::FCP_IRQ_IDLE;
            end
         end
         // codes outside the two states fall back to idle
         default: begin
            next_s.irq = fcp_pkg::FCP_IRQ_IDLE;
         end
      endcase

      // enable/disable; disable leaves pending intact
      if (irq_allow_op) begin
         next_s.st.irq_allow_bit = 1'b1;
      end else if (irq_block_op) begin
         next_s.st.irq_allow_bit = 1'b0;
      end

      // image accumulator copy
      if (acc_copy_bit || fast_count_op) begin
         next_s.img_acc = acc_step;
      end

      // parameter load, mask/source now, preset staged
      if (limit_output_load_op) begin
         if (load_ok) begin
            next_s.hw.mask = load_params.mask;
            next_s.hw.high_src = load_params.high_src;
            next_s.stage_high = load_params.high_lim;
            next_s.stage_pend = 1'b1;
            if (cfg_bidir) begin
               // up counters ignore the last two words
               next_s.hw.low_src = load_params.low_src;
               next_s.stage_low = load_params.low_lim;
            end else begin
               next_s.stage_low = s.hw.low_lim;
            end
         end else begin
            next_s.fault = 1'b1;
         end
      end

      // clear / write accumulator override the count, copy, flags, cause and routine start
      if (acc_clear_op || acc_write_op) begin
         next_s.acc = acc_clear_op ? fcp_pkg::ACC_ZERO : acc_write_val;
         next_s.img_acc = acc_clear_op ? fcp_pkg::ACC_ZERO : acc_write_val;
         next_s.st.queued_flag = 1'b0;
         next_s.st.dropped_flag = 1'b0;
         next_s.st.top_wrap_flag = 1'b0;
         next_s.st.low_wrap_flag = 1'b0;
         next_s.st.count_done_flag = 1'b0;
         next_s.st.cause = fcp_pkg::CAUSE_NONE;
         next_s.isr_go = 1'b0;
         if (s.irq == fcp_pkg::FCP_IRQ_IDLE) begin
            next_s.irq = fcp_pkg::FCP_IRQ_IDLE;
         end
         if (!cfg_bidir) begin
            next_s.hw.high_lim = instr_high_lim;
            next_s.stage_pend = 1'b0;
         end
      end

      // forces sit over the counter/program output latch, not the output image
      next_s.phys = (next_s.out_lat & ~force_out_en) | (force_out_val & force_out_en);
   end

   // ============================================================
   // register the state; enable bit resets to 1
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s <= '0;
         s.hw.low_lim <= fcp_pkg::ACC_MIN;
         s.stage_low <= fcp_pkg::ACC_MIN;
         s.hw.high_lim <= fcp_pkg::ACC_MAX;
         s.stage_high <= fcp_pkg::ACC_MAX;
         s.irq <= fcp_pkg::FCP_IRQ_IDLE;
         s.st.irq_allow_bit <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ============================================================
   // outputs straight from flops
   assign phys_out = s.phys;
   assign out_image = s.oimg;
   assign image_acc = s.img_acc;
   assign hw_acc = s.acc;
   assign isr_start = s.isr_go;
   assign load_fault = s.fault;
   assign status = s.st;
endmodule
`default_nettype wire
